// ==== lbc_core.sv ====
// Purpose: Execution unit for logic, branch, call and clear operations of a 16-bit core
// Assumes: Decoded commands arrive with the address of the following instruction
// Notes: Memory read data return one cycle after the read strobe
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module lbc_core
  import lbc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire lbc_cmd_s CMD,
  output logic CMD_READY,
  output logic DONE,
  output logic [15:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic [1:0] MEM_BE,
  output logic MEM_WR,
  output logic MEM_RD,
  input wire logic [15:0] MEM_RDATA,
  input wire logic [1:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SRC_REQ, ST_SRC_DATA, ST_DST_SEL, ST_DST_REQ, ST_DST_DATA, ST_EXEC, ST_WRITE
  } lbc_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_q;
  logic rst_n_q;

  // Asynchronous assert, two-stage release
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  lbc_state_e state_q;
  lbc_cmd_s cmd_q;
  lbc_cmd_s cmd_n;
  logic [15:0] regs_q [16];
  logic [15:0] src_q;
  logic [15:0] dst_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [1:0] be_q;
  logic rd_q;
  logic wr_q;
  logic done_q;
  logic [15:0] reg_rdata_q;
  logic cmd_acc;
  logic src_from_mem;
  logic [15:0] src_now;
  logic [15:0] src_addr;
  logic [15:0] dst_addr;
  logic [15:0] mem_byte;
  logic [15:0] alu_dst;
  lbc_op_e alu_op;
  logic [15:0] alu_res;
  logic [15:0] alu_flags;
  logic alu_store;
  logic alu_flags_we;
  logic need_dst;
  logic dst_in_mem;
  logic is_flow;
  logic [15:0] sp_next;
  logic [15:0] step;

  assign cmd_acc = CMD_VALID && (state_q == ST_IDLE);
  assign CMD_READY = (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Command normalisation

  // Flag clears become bit clear on the status register; flow ops are word only
  always_comb begin
    cmd_n = CMD;
    case (CMD.op)
      LBC_CLEAR_CARRY, LBC_CLEAR_NEG, LBC_CLEAR_ZERO: begin
        cmd_n.byte_op = 1'b0;
        cmd_n.src_mode = LBC_SM_IMM;
        cmd_n.dst_mode = LBC_DM_REG;
        cmd_n.dst_reg = LBC_STATUS_IDX;
        cmd_n.src_ext = (CMD.op == LBC_CLEAR_CARRY) ? LBC_CARRY_MASK :
                        (CMD.op == LBC_CLEAR_NEG) ? LBC_NEG_MASK : LBC_ZERO_MASK;
      end
      LBC_BRANCH, LBC_CALL: begin
        cmd_n.byte_op = 1'b0;
      end
      LBC_CLEAR: begin
        cmd_n.src_mode = LBC_SM_IMM;
        cmd_n.src_ext = 16'h0000;
      end
      default: begin
        cmd_n = CMD;
      end
    endcase
  end

  // Source operand location; every source mode serves branch and call too
  always_comb begin
    src_from_mem = 1'b0;
    src_now = cmd_n.src_ext;
    src_addr = regs_q[cmd_n.src_reg];
    case (cmd_n.src_mode)
      LBC_SM_REG: src_now = regs_q[cmd_n.src_reg];
      LBC_SM_IMM: src_now = cmd_n.src_ext;
      LBC_SM_INDEXED: begin
        src_from_mem = 1'b1;
        src_addr = regs_q[cmd_n.src_reg] + cmd_n.src_ext;
      end
      LBC_SM_ABS: begin
        src_from_mem = 1'b1;
        src_addr = cmd_n.src_ext;
      end
      default: src_from_mem = 1'b1;
    endcase
  end

  assign dst_in_mem = (cmd_q.dst_mode != LBC_DM_REG);
  assign dst_addr = (cmd_q.dst_mode == LBC_DM_ABS) ? cmd_q.dst_ext :
                    regs_q[cmd_q.dst_reg] + cmd_q.dst_ext;
  assign need_dst = (cmd_q.op != LBC_CLEAR) && !is_flow;
  assign is_flow = (cmd_q.op == LBC_BRANCH) || (cmd_q.op == LBC_CALL);
  assign step = cmd_q.byte_op ? LBC_BYTE_STEP : LBC_WORD_STEP;
  assign sp_next = regs_q[LBC_SP_IDX] - LBC_STACK_STEP;
  // Byte reads pick the lane named by the address low bit
  assign mem_byte = addr_q[0] ? {8'h00, MEM_RDATA[15:8]} : {8'h00, MEM_RDATA[7:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // Logic unit

  // Flag clears run through the plain bit clear path
  always_comb begin
    case (cmd_q.op)
      LBC_CLEAR_CARRY, LBC_CLEAR_NEG, LBC_CLEAR_ZERO: alu_op = LBC_BIT_CLEAR;
      default: alu_op = cmd_q.op;
    endcase
  end

  assign alu_dst = dst_in_mem ? dst_q : regs_q[cmd_q.dst_reg];

  lbc_logic_alu u_alu (
    .op(alu_op),
    .byte_op(cmd_q.byte_op),
    .src(src_q),
    .dst(alu_dst),
    .flags_in(regs_q[LBC_STATUS_IDX]),
    .result(alu_res),
    .flags_out(alu_flags),
    .store(alu_store),
    .flags_we(alu_flags_we)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and memory requests

  // One memory access at a time; strobes are one cycle long
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      src_q <= LBC_REG_RESET;
      dst_q <= LBC_REG_RESET;
      addr_q <= LBC_REG_RESET;
      wdata_q <= LBC_REG_RESET;
      be_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_acc) begin
            cmd_q <= cmd_n;
            if (src_from_mem) begin
              addr_q <= src_addr;
              be_q <= cmd_n.byte_op ? (src_addr[0] ? 2'h2 : 2'h1) : 2'h3;
              rd_q <= 1'b1;
              state_q <= ST_SRC_REQ;
            end else begin
              src_q <= src_now;
              state_q <= ST_DST_SEL;
            end
          end
        end
        ST_SRC_REQ: state_q <= ST_SRC_DATA;
        ST_SRC_DATA: begin
          src_q <= cmd_q.byte_op ? mem_byte : MEM_RDATA;
          state_q <= ST_DST_SEL;
        end
        ST_DST_SEL: begin
          if (need_dst && dst_in_mem) begin
            addr_q <= dst_addr;
            be_q <= cmd_q.byte_op ? (dst_addr[0] ? 2'h2 : 2'h1) : 2'h3;
            rd_q <= 1'b1;
            state_q <= ST_DST_REQ;
          end else begin
            state_q <= ST_EXEC;
          end
        end
        ST_DST_REQ: state_q <= ST_DST_DATA;
        ST_DST_DATA: begin
          dst_q <= cmd_q.byte_op ? mem_byte : MEM_RDATA;
          state_q <= ST_EXEC;
        end
        ST_EXEC: begin
          if (cmd_q.op == LBC_CALL) begin
            addr_q <= sp_next;
            wdata_q <= regs_q[LBC_PC_IDX];
            be_q <= 2'h3;
            wr_q <= 1'b1;
            state_q <= ST_WRITE;
          end else if (alu_store && dst_in_mem) begin
            addr_q <= dst_addr;
            wdata_q <= cmd_q.byte_op ? {alu_res[7:0], alu_res[7:0]} : alu_res;
            be_q <= cmd_q.byte_op ? (dst_addr[0] ? 2'h2 : 2'h1) : 2'h3;
            wr_q <= 1'b1;
            state_q <= ST_WRITE;
          end else begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign MEM_ADDR = addr_q;
  assign MEM_WDATA = wdata_q;
  assign MEM_BE = be_q;
  assign MEM_RD = rd_q;
  assign MEM_WR = wr_q;
  assign DONE = done_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  // Software writes land only while idle and no command is taken
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= LBC_REG_RESET;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_acc) begin
            regs_q[LBC_PC_IDX] <= CMD.next_pc;
          end else if (REG_WR) begin
            case (REG_ADDR)
              LBC_OFS_STATUS_REG: regs_q[LBC_STATUS_IDX] <= REG_WDATA;
              LBC_OFS_PC: regs_q[LBC_PC_IDX] <= REG_WDATA;
              LBC_OFS_SP: regs_q[LBC_SP_IDX] <= REG_WDATA;
              default: regs_q[LBC_STATUS_IDX] <= regs_q[LBC_STATUS_IDX];
            endcase
          end
        end
        ST_SRC_DATA: begin
          // Pointer bumps after the target word was read
          if (cmd_q.src_mode == LBC_SM_AUTOINC) begin
            regs_q[cmd_q.src_reg] <= regs_q[cmd_q.src_reg] + step;
          end
        end
        ST_EXEC: begin
          if (cmd_q.op == LBC_BRANCH) begin
            regs_q[LBC_PC_IDX] <= src_q;
          end else if (cmd_q.op == LBC_CALL) begin
            regs_q[LBC_SP_IDX] <= sp_next;
          end else begin
            if (alu_flags_we) begin
              regs_q[LBC_STATUS_IDX] <= alu_flags;
            end
            // Status as destination keeps its mode bits
            if (alu_store && !dst_in_mem) begin
              if (cmd_q.dst_reg == LBC_STATUS_IDX) begin
                regs_q[LBC_STATUS_IDX] <= (alu_res & ~LBC_MODE_MASK) |
                                          (regs_q[LBC_STATUS_IDX] & LBC_MODE_MASK);
              end else begin
                regs_q[cmd_q.dst_reg] <= alu_res;
              end
            end
          end
        end
        ST_WRITE: begin
          // Target loads only after the return address went out
          if (cmd_q.op == LBC_CALL) begin
            regs_q[LBC_PC_IDX] <= src_q;
          end
        end
        default: regs_q[LBC_PC_IDX] <= regs_q[LBC_PC_IDX];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port read

  // Data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_q <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        LBC_OFS_STATUS_REG: reg_rdata_q <= regs_q[LBC_STATUS_IDX];
        LBC_OFS_PC: reg_rdata_q <= regs_q[LBC_PC_IDX];
        LBC_OFS_SP: reg_rdata_q <= regs_q[LBC_SP_IDX];
        default: reg_rdata_q <= {8'h00, (state_q != ST_IDLE), 3'h0, cmd_q.op};
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  assign REG_RDATA = reg_rdata_q;

endmodule

// ==== lbc_logic_alu.sv ====
// Purpose: Bitwise logic and flag evaluation for the execution unit
// Assumes: Flag clearing operations arrive as bit clear with the mask as source
// Notes: Purely combinational
`timescale 1ns/1ps
module lbc_logic_alu
  import lbc_pkg::*;
(
  input wire lbc_op_e op,
  input wire logic byte_op,
  input wire logic [15:0] src,
  input wire logic [15:0] dst,
  input wire logic [15:0] flags_in,
  output logic [15:0] result,
  output logic [15:0] flags_out,
  output logic store,
  output logic flags_we
);

  logic [15:0] raw;
  logic msb;
  logic zero;

  // Raw operation and store decision
  always_comb begin
    raw = dst;
    store = 1'b0;
    flags_we = 1'b0;
    case (op)
      LBC_AND: begin
        raw = src & dst;
        store = 1'b1;
        flags_we = 1'b1;
      end
      LBC_BIT_TEST: begin
        raw = src & dst;
        flags_we = 1'b1;
      end
      LBC_BIT_CLEAR: begin
        raw = ~src & dst;
        store = 1'b1;
      end
      LBC_BIT_SET: begin
        raw = src | dst;
        store = 1'b1;
      end
      LBC_CLEAR: begin
        raw = 16'h0000;
        store = 1'b1;
      end
      default: begin
        raw = dst;
      end
    endcase
  end

  // Byte size touches the low byte only, bit 7 is the sign
  assign result = byte_op ? {dst[15:8], raw[7:0]} : raw;
  assign msb = byte_op ? raw[7] : raw[15];
  assign zero = byte_op ? (raw[7:0] == 8'h00) : (raw == 16'h0000);

  // Flag image; carry is the OR of the result so a single tested bit lands in carry
  always_comb begin
    flags_out = flags_in;
    flags_out[LBC_N_BIT] = msb;
    flags_out[LBC_Z_BIT] = zero;
    flags_out[LBC_C_BIT] = ~zero;
    flags_out[LBC_V_BIT] = 1'b0;
  end

endmodule

// ==== lbc_mem_model.sv ====
// Purpose: Program and data memory answering the unit's memory bus
// Assumes: Byte addresses, 256 words mirrored over the space
// Notes: Bench preloads and inspects the array directly
`timescale 1ns/1ps
module lbc_mem_model (
  input wire logic SYS_CLK,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [1:0] MEM_BE,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  output logic [15:0] MEM_RDATA
);
  logic [15:0] mem [0:255];
  logic rd_q = 1'b0;
  logic [15:0] last_q = 16'h0000;
  // Data only in the slot after the strobe, inverted elsewhere so stale use shows
  assign MEM_RDATA = rd_q ? last_q : ~last_q;
  // Plain always so the bench may also poke the array
  always @(posedge SYS_CLK) begin
    rd_q <= MEM_RD;
    if (MEM_RD)
      last_q <= mem[MEM_ADDR[8:1]];
    if (MEM_WR && MEM_BE[0])
      mem[MEM_ADDR[8:1]][7:0] <= MEM_WDATA[7:0];
    if (MEM_WR && MEM_BE[1])
      mem[MEM_ADDR[8:1]][15:8] <= MEM_WDATA[15:8];
  end
endmodule

// ==== lbc_pkg.sv ====
// Purpose: Shared constants and types for the logic, branch and call execution unit
// Assumes: 16-bit word machine, byte addressed memory, one system clock
// Notes: Status layout carry 0, zero 1, negative 2, mode bits 3..5, overflow 8
package lbc_pkg;

  // Operations handled by this unit
  typedef enum logic [3:0] {
    LBC_AND, LBC_BIT_CLEAR, LBC_BIT_SET, LBC_BIT_TEST, LBC_BRANCH,
    LBC_CALL, LBC_CLEAR, LBC_CLEAR_CARRY, LBC_CLEAR_NEG, LBC_CLEAR_ZERO
  } lbc_op_e;

  // Source addressing modes
  typedef enum logic [2:0] {
    LBC_SM_REG, LBC_SM_INDEXED, LBC_SM_ABS, LBC_SM_INDIRECT, LBC_SM_AUTOINC, LBC_SM_IMM
  } lbc_src_mode_e;

  // Destination addressing modes
  typedef enum logic [1:0] {
    LBC_DM_REG, LBC_DM_INDEXED, LBC_DM_ABS
  } lbc_dst_mode_e;

  // One decoded instruction handed over by the fetch/decode stage
  typedef struct packed {
    lbc_op_e       op;
    logic          byte_op;
    lbc_src_mode_e src_mode;
    logic [3:0]    src_reg;
    logic [15:0]   src_ext;
    lbc_dst_mode_e dst_mode;
    logic [3:0]    dst_reg;
    logic [15:0]   dst_ext;
    logic [15:0]   next_pc;
  } lbc_cmd_s;

  // Register indices of the core register file
  localparam logic [3:0] LBC_PC_IDX = 4'h0;
  localparam logic [3:0] LBC_SP_IDX = 4'h1;
  localparam logic [3:0] LBC_STATUS_IDX = 4'h2;

  // Status register bit positions
  localparam int LBC_C_BIT = 0;
  localparam int LBC_Z_BIT = 1;
  localparam int LBC_N_BIT = 2;
  localparam int LBC_INT_ENABLE_BIT = 3;
  localparam int LBC_PROC_OFF_BIT = 4;
  localparam int LBC_OSC_OFF_BIT = 5;
  localparam int LBC_V_BIT = 8;

  // Mode bits that no operation here may touch
  localparam logic [15:0] LBC_MODE_MASK = 16'h0038;

  // Constant masks of the flag clearing operations
  localparam logic [15:0] LBC_CARRY_MASK = 16'h0001;
  localparam logic [15:0] LBC_NEG_MASK = 16'h0004;
  localparam logic [15:0] LBC_ZERO_MASK = 16'h0002;

  // Pointer steps
  localparam logic [15:0] LBC_STACK_STEP = 16'h0002;
  localparam logic [15:0] LBC_WORD_STEP = 16'h0002;
  localparam logic [15:0] LBC_BYTE_STEP = 16'h0001;

  // Reset values
  localparam logic [15:0] LBC_REG_RESET = 16'h0000;

  // Register port offsets
  localparam logic [1:0] LBC_OFS_STATUS_REG = 2'h0;
  localparam logic [1:0] LBC_OFS_PC = 2'h1;
  localparam logic [1:0] LBC_OFS_SP = 2'h2;
  localparam logic [1:0] LBC_OFS_UNIT_STATE = 2'h3;

endpackage

// ==== lbc_sva.sv ====
// Purpose: Port-level checks on the logic, branch and call execution unit
// Assumes: Ports exactly as the top module declares them
// Notes: Operation results are compared by the bench, timing and bus shape here
`timescale 1ns/1ps
module lbc_sva
  import lbc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CMD_VALID,
  input wire lbc_cmd_s CMD,
  input wire logic CMD_READY,
  input wire logic DONE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [1:0] MEM_BE,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic [15:0] MEM_RDATA,
  input wire logic [1:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic take;
  logic [15:0] npc_q;
  assign take = CMD_VALID && CMD_READY;
  // Return address held from the taking edge, the push comes cycles later
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N)
      npc_q <= 16'h0000;
    else if (take)
      npc_q <= CMD.next_pc;
  end
  ////////////////////////////////////////////////////////////////////////
  // Handshake shape
  a_done_single: assert property (DONE |=> !DONE) else $error("done held too long");
  a_busy_take: assert property (take |=> !CMD_READY) else $error("ready after take");
  a_ready_done: assert property (DONE |-> CMD_READY) else $error("not ready at done");
  a_strobe_excl: assert property (!(MEM_RD && MEM_WR)) else $error("read and write");
  a_regrd_zero: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data outside slot");
  // Operations that must never store
  a_branch_no_store: assert property (take && CMD.op == LBC_BRANCH |=> !MEM_WR [*6])
    else $error("branch wrote memory");
  a_test_no_store: assert property (take && CMD.op == LBC_BIT_TEST |=> !MEM_WR [*6])
    else $error("bit test wrote memory");
  a_flag_no_mem: assert property (take && CMD.op inside {LBC_CLEAR_CARRY,
    LBC_CLEAR_NEG, LBC_CLEAR_ZERO} |=> !(MEM_RD || MEM_WR) [*2])
    else $error("flag clear used memory");
  // Stores that must carry exact values
  a_call_push: assert property (take && CMD.op == LBC_CALL |-> ##[2:8]
    (MEM_WR && MEM_BE == 2'b11 && MEM_WDATA == npc_q))
    else $error("call push wrong");
  a_clear_zero: assert property (take && CMD.op == LBC_CLEAR &&
    CMD.dst_mode != LBC_DM_REG |-> ##[2:8] (MEM_WR && MEM_WDATA == 16'h0000))
    else $error("clear did not store zero");
  c_call: cover property (take && CMD.op == LBC_CALL);
  c_branch: cover property (take && CMD.op == LBC_BRANCH);
  c_test_byte: cover property (take && CMD.op == LBC_BIT_TEST && CMD.byte_op);
endmodule

bind lbc_core lbc_sva u_sva (.SYS_CLK, .RST_N, .CMD_VALID, .CMD, .CMD_READY, .DONE,
  .MEM_ADDR, .MEM_WDATA, .MEM_BE, .MEM_WR, .MEM_RD, .MEM_RDATA, .REG_ADDR, .REG_WDATA,
  .REG_WR, .REG_RD, .REG_RDATA);

// ==== tb.sv ====
// Purpose: Self-checking bench for the logic, branch and call execution unit
// Assumes: Commands issued only while idle, one at a time
// Notes: Seeded random operands mixed with single-bit and byte-lane corners
`timescale 1ns/1ps
module tb;
  import lbc_pkg::*;
  logic SYS_CLK, RST_N, CMD_VALID, CMD_READY, DONE, MEM_WR, MEM_RD, REG_WR, REG_RD, b;
  lbc_cmd_s CMD;
  lbc_op_e op;
  lbc_src_mode_e sm;
  lbc_dst_mode_e dm;
  logic [1:0] MEM_BE, REG_ADDR;
  logic [15:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, REG_WDATA, REG_RDATA;
  logic [15:0] s, d, stat, r, a, rd;
  logic [15:0] msk [3] = '{LBC_CARRY_MASK, LBC_NEG_MASK, LBC_ZERO_MASK};
  int n_fail = 0;
  int comparisons = 0;
  int seed = 80;
  lbc_core DUT (.SYS_CLK, .RST_N, .CMD_VALID, .CMD, .CMD_READY, .DONE, .MEM_ADDR, .MEM_WDATA,
    .MEM_BE, .MEM_WR, .MEM_RD, .MEM_RDATA, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA);
  lbc_mem_model u_mem (.SYS_CLK, .MEM_ADDR, .MEM_WDATA, .MEM_BE, .MEM_WR, .MEM_RD, .MEM_RDATA);
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [1:0] ad, input logic [15:0] v);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= ad;
    REG_WDATA <= v;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] ad, output logic [15:0] v);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= ad;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask
  // Offered while idle, so the first edge takes it; done waited for under a bound
  task automatic run(input lbc_cmd_s c);
    int k;
    @(posedge SYS_CLK);
    CMD <= c;
    CMD_VALID <= 1'b1;
    @(posedge SYS_CLK);
    CMD_VALID <= 1'b0;
    for (k = 0; k < 40 && DONE !== 1'b1; k++) @(posedge SYS_CLK);
    if (k == 40) begin
      n_fail++;
      $display("mismatch at %0t: command never finished", $time);
      final_report();
    end
  endtask
  function automatic lbc_cmd_s mk(lbc_op_e o, logic bo, lbc_src_mode_e sm, logic [15:0] sx,
    lbc_dst_mode_e dm, logic [15:0] dx, logic [15:0] np);
    return '{o, bo, sm, 4'h4, sx, dm, 4'h5, dx, np};
  endfunction
  // Flags of AND and bit test; byte size takes bit 7 as sign
  function automatic logic [15:0] fl(logic [15:0] x, logic [15:0] rr, logic bb);
    logic z;
    z = bb ? (rr[7:0] == 8'h00) : (rr == 16'h0000);
    x[LBC_N_BIT] = bb ? rr[7] : rr[15];
    x[LBC_Z_BIT] = z;
    x[LBC_C_BIT] = !z;
    x[LBC_V_BIT] = 1'b0;
    return x;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_fail++;
    $display("mismatch at %0t: run did not finish", $time);
    final_report();
  end
  initial begin
    {RST_N, CMD_VALID, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    CMD = '0;
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    for (int i = 0; i < 3; i++) begin
      reg_rd(2'(i), rd);
      chk(rd, 16'h0000, "reset value");
    end
    // Logic ops on memory, single-bit masks first
    for (int i = 0; i < 40; i++) begin
      op = lbc_op_e'(4'(i % 4));
      b = i[2];
      stat = 16'($random(seed));
      d = 16'($random(seed));
      s = (i < 16) ? 16'h0001 << (i % 8) : 16'($random(seed));
      a = 16'h0040 + 16'(2 * i);
      // Last passes fetch the source from memory; some reach the target indexed off zero R5
      sm = LBC_SM_IMM;
      dm = LBC_DM_ABS;
      if (i >= 32) begin
        sm = LBC_SM_ABS;
      end
      if (i[3]) begin
        dm = LBC_DM_INDEXED;
      end
      u_mem.mem[a[8:1]] = d;
      u_mem.mem[a[8:1] + 8'h40] = s;
      reg_wr(LBC_OFS_STATUS_REG, stat);
      run(mk(op, b, sm, (i < 32) ? s : a + 16'h0080, dm, a, 16'h0000));
      r = (op == LBC_BIT_CLEAR) ? ~s & d : (op == LBC_BIT_SET) ? s | d : s & d;
      r = b ? {d[15:8], r[7:0]} : r;
      chk(u_mem.mem[a[8:1]], (op == LBC_BIT_TEST) ? d : r, "memory");
      chk(u_mem.mem[a[8:1] + 8'h40], s, "source kept");
      reg_rd(LBC_OFS_STATUS_REG, rd);
      r = (op inside {LBC_AND, LBC_BIT_TEST}) ? fl(stat, r, b) : stat;
      chk(rd, r, "status");
    end
    $display("test logic ops done");
    for (int j = 0; j < 3; j++) begin
      stat = 16'($random(seed)) | 16'h0007;
      reg_wr(LBC_OFS_STATUS_REG, stat);
      run(mk(lbc_op_e'(4'(7 + j)), 1'b0, LBC_SM_REG, 16'h0000, LBC_DM_REG, 16'h0000, 16'h0000));
      reg_rd(LBC_OFS_STATUS_REG, rd);
      chk(rd, stat & ~msk[j], "flag clear");
    end
    stat = stat & ~msk[2];
    // Word clear, then byte clear of the high lane
    for (int j = 0; j < 2; j++) begin
      d = 16'($random(seed));
      a = 16'h0020 | 16'(j);
      u_mem.mem[a[8:1]] = d;
      run(mk(LBC_CLEAR, j[0], LBC_SM_IMM, 16'h0000, LBC_DM_ABS, a, 16'h0000));
      chk(u_mem.mem[a[8:1]], (j == 1) ? {8'h00, d[7:0]} : 16'h0000, "clear");
    end
    $display("test clears done");
    d = 16'($random(seed));
    run(mk(LBC_BRANCH, 1'b0, LBC_SM_IMM, d, LBC_DM_REG, 16'h0000, 16'h0100));
    reg_rd(LBC_OFS_PC, rd);
    chk(rd, d, "branch target");
    // Pointer register starts at zero and steps a word each time
    for (int j = 0; j < 2; j++) begin
      d = 16'($random(seed));
      u_mem.mem[j] = d;
      run(mk(LBC_BRANCH, 1'b0, LBC_SM_AUTOINC, 16'h0000, LBC_DM_REG, 16'h0000, 16'h0100));
      reg_rd(LBC_OFS_PC, rd);
      chk(rd, d, "autoincrement branch");
    end
    d = 16'($random(seed));
    u_mem.mem[10] = d;
    reg_wr(LBC_OFS_SP, 16'h0180);
    run(mk(LBC_CALL, 1'b0, LBC_SM_INDEXED, 16'h0010, LBC_DM_REG, 16'h0000, 16'h0246));
    chk(u_mem.mem[8'hbf], 16'h0246, "pushed return");
    reg_rd(LBC_OFS_SP, rd);
    chk(rd, 16'h017e, "stack pointer");
    reg_rd(LBC_OFS_PC, rd);
    chk(rd, d, "call target");
    reg_rd(LBC_OFS_STATUS_REG, rd);
    chk(rd, stat, "status kept");
    reg_wr(LBC_OFS_UNIT_STATE, 16'hffff);
    reg_rd(LBC_OFS_UNIT_STATE, rd);
    chk(rd, 16'h0005, "unit state");
    // Pointer register now holds two word steps; branch straight from it
    run(mk(LBC_BRANCH, 1'b0, LBC_SM_REG, 16'h0000, LBC_DM_REG, 16'h0000, 16'h0100));
    reg_rd(LBC_OFS_PC, rd);
    chk(rd, LBC_WORD_STEP + LBC_WORD_STEP, "register branch");
    $display("test transfers done");
    final_report();
  end
endmodule
